// [include/reclock_ctrl_regs.vh]
// Register map, field positions, codes and timing for the reclock control block
`ifndef RECLOCK_CTRL_REGS_VH
`define RECLOCK_CTRL_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_SETTINGS     8'h00
`define REG_ACTIVE       8'h04
`define REG_COMMAND      8'h08
`define REG_STATUS       8'h0c
`define REG_ALARM        8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_MODE_LO        0
`define F_MODE_HI        3
`define F_OPT1_EN        4
`define F_OPT2_EN        5
`define F_IN_SEL         6
`define F_CMD_APPLY      0
`define F_CMD_RECALL     1
`define F_CMD_LOCATE     2

// ----------------------------------------
// Modes
// ----------------------------------------
`define MODE_AUTO_RATE_ASI_PREF    4'h0
`define MODE_AUTO_SD     4'h1
`define MODE_BYPASS      4'h2
`define MODE_R143        4'h3
`define MODE_R177        4'h4
`define MODE_R270        4'h5
`define MODE_R360        4'h6
`define MODE_R540        4'h7
`define MODE_R1485       4'h8

// ----------------------------------------
// Rate codes (also rate select to reclocker)
// ----------------------------------------
`define RATE_143         3'h0
`define RATE_177         3'h1
`define RATE_270         3'h2
`define RATE_360         3'h3
`define RATE_540         3'h4
`define RATE_1485        3'h5
`define RATE_NA          3'h6
`define RATE_UNKNOWN     3'h7

// ----------------------------------------
// Submodule type and tri-state report codes
// ----------------------------------------
`define SUB_NONE         3'h0
`define SUB_ERROR        3'h1
`define SUB_UNKNOWN      3'h2
`define SUB_DUAL_TX      3'h3
`define SUB_TRX          3'h4
`define TRI_YES          2'h0
`define TRI_NO           2'h1
`define TRI_NA           2'h2

// ----------------------------------------
// Reset value and timing
// ----------------------------------------
`define SETTINGS_RESET   7'h30
`define FLASH_HALF_MS    250
`define CLK_KHZ          25000
`define FLASH_HALF_CYC   (`FLASH_HALF_MS * `CLK_KHZ)

`endif

// [rtl/pin_sync.v]
// Two-flop synchroniser for a bus of asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [rtl/reclock_ctrl.v]
// Reclock mode, optic control, status reporting and indicators with AXI4-Lite slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "reclock_ctrl_regs.vh"
module reclock_ctrl #(
    parameter FLASH_HALF = `FLASH_HALF_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [3:0]  jumper_mode,
    input  wire [2:0]  jumper_flags,
    input  wire [2:0]  sub_type,
    input  wire        sub_fault,
    input  wire        coax_present,
    input  wire        optic1_present,
    input  wire        optic2_present,
    input  wire        lock,
    input  wire [2:0]  rate_detect,
    input  wire        asi_detect,
    input  wire        front_is_16,
    input  wire        rear_present,
    input  wire        rear_is_16,
    input  wire        ref_lost,
    output reg         reclock_bypass,
    output reg  [2:0]  rate_sel,
    output reg         rate_fixed,
    output reg         output_invalid,
    output reg         optic1_tx_en,
    output reg         optic2_tx_en,
    output reg         input_sel_optic,
    output reg         indicator_a,
    output reg         config_indicator,
    output reg         fault_led,
    output reg         mismatch_warn,
    output reg         state_yellow,
    output reg         alarm_fault,
    output reg         alarm_sig_loss,
    output reg         alarm_ref_loss,
    output reg         alarm_cfg_err
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [22:0] pins_s;
    pin_sync #(.WIDTH(23)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({jumper_mode, jumper_flags, sub_type, sub_fault, coax_present,
                    optic1_present, optic2_present, lock, rate_detect, asi_detect,
                    front_is_16, rear_present, rear_is_16, ref_lost}),
        .sync_out (pins_s)
    );
    wire [3:0] jmp_mode_s = pins_s[22:19];
    wire [2:0] jmp_flag_s = pins_s[18:16];
    wire [2:0] sub_s      = pins_s[15:13];
    wire       sub_flt_s  = pins_s[12];
    wire       coax_s     = pins_s[11];
    wire       opt1_s     = pins_s[10];
    wire       opt2_s     = pins_s[9];
    wire       lock_s     = pins_s[8];
    wire [2:0] rate_s     = pins_s[7:5];
    wire       asi_s      = pins_s[4];
    wire       front16_s  = pins_s[3];
    wire       rear_s     = pins_s[2];
    wire       rear16_s   = pins_s[1];
    wire       ref_lost_s = pins_s[0];

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [2:0] fixed_rate;
        input [3:0] m;
        begin
            fixed_rate = m[2:0] - 3'h3;
        end
    endfunction

    function is_fixed;
        input [3:0] m;
        begin
            is_fixed = (m >= `MODE_R143) && (m <= `MODE_R1485);
        end
    endfunction

    // ----------------------------------------
    // Settings: pending (software) and active
    // ----------------------------------------
    reg  [6:0] pend_q;
    reg  [6:0] act_q;
    reg        locate_q;
    reg        recall_pend_q;
    reg  [1:0] warm_q;
    wire [3:0] act_mode = act_q[`F_MODE_HI:`F_MODE_LO];
    wire       trx_fit  = (sub_s == `SUB_TRX);
    wire       dual_fit = (sub_s == `SUB_DUAL_TX);

    // AXI write channel capture: address and data in either order
    reg        aw_have_q;
    reg        w_have_q;
    reg [7:0]  aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    wire       wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    wire       wr_lane = w_strb_q[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q & 8'hfc)
                    `REG_SETTINGS, `REG_COMMAND: s_axi_bresp <= 2'h0;
                    `REG_ACTIVE, `REG_STATUS, `REG_ALARM: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Settings and commands; recall overrides apply in the same write
    always @(posedge aclk) begin
        if (!aresetn) begin
            pend_q        <= `SETTINGS_RESET;
            act_q         <= `SETTINGS_RESET;
            locate_q      <= 1'b0;
            recall_pend_q <= 1'b1;
            warm_q        <= 2'h0;
        end else begin
            warm_q <= {warm_q[0], 1'b1};
            if (recall_pend_q && warm_q[1]) begin // Wait until sync chain holds jumpers
                pend_q        <= {jmp_flag_s, jmp_mode_s};
                act_q         <= {jmp_flag_s, jmp_mode_s};
                recall_pend_q <= 1'b0;
            end
            if (wr_fire && wr_lane) begin
                if ((aw_addr_q & 8'hfc) == `REG_SETTINGS)
                    pend_q <= w_data_q[6:0];
                if ((aw_addr_q & 8'hfc) == `REG_COMMAND) begin
                    if (w_data_q[`F_CMD_APPLY])
                        act_q <= pend_q;
                    if (w_data_q[`F_CMD_RECALL])
                        recall_pend_q <= 1'b1;
                    locate_q <= w_data_q[`F_CMD_LOCATE];
                end
            end
        end
    end

    // ----------------------------------------
    // Reclocker steering
    // ----------------------------------------
    reg        bypass_d;
    reg [2:0]  rate_d;
    reg        invalid_d;
    reg [1:0]  lock_rep_d;
    reg [2:0]  rate_rep_d;
    reg        rate_ok;

    always @* begin
        bypass_d   = 1'b0;
        rate_d     = rate_s;
        invalid_d  = 1'b0;
        lock_rep_d = lock_s ? `TRI_YES : `TRI_NO;
        rate_rep_d = lock_s ? rate_s : `RATE_UNKNOWN;
        rate_ok    = 1'b1;
        case (act_mode)
            `MODE_AUTO_RATE_ASI_PREF: begin
                rate_ok  = (rate_s != `RATE_177);
                bypass_d = !(lock_s && rate_ok);
            end
            `MODE_AUTO_SD: begin
                rate_ok  = !asi_s;
                bypass_d = !(lock_s && rate_ok);
            end
            `MODE_BYPASS: begin
                bypass_d   = 1'b1;
                lock_rep_d = `TRI_NA;
                rate_rep_d = `RATE_NA;
            end
            default: begin
                if (is_fixed(act_mode)) begin
                    rate_d    = fixed_rate(act_mode);
                    invalid_d = !lock_s;
                end else begin
                    bypass_d   = 1'b1;
                    lock_rep_d = `TRI_NA;
                    rate_rep_d = `RATE_NA;
                end
            end
        endcase
        if (!rate_ok)
            rate_rep_d = `RATE_UNKNOWN;
    end

    // ----------------------------------------
    // Rear module checks and status codes
    // ----------------------------------------
    wire mismatch = rear_s && front16_s && !rear16_s;
    wire rear_bad = !rear_s || mismatch;
    wire opt1_on  = trx_fit && act_q[`F_OPT1_EN];
    wire opt2_on  = trx_fit && act_q[`F_IN_SEL];
    wire coax_on  = !(trx_fit && act_q[`F_IN_SEL]);

    reg [1:0] health_q;
    reg [1:0] coax_rep_q;
    reg [1:0] opt1_rep_q;
    reg [1:0] opt2_rep_q;
    reg [1:0] lock_rep_q;
    reg [2:0] rate_rep_q;
    reg [2:0] sub_rep_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            health_q   <= `TRI_NA;
            coax_rep_q <= `TRI_NA;
            opt1_rep_q <= `TRI_NA;
            opt2_rep_q <= `TRI_NA;
            lock_rep_q <= `TRI_NA;
            rate_rep_q <= `RATE_NA;
            sub_rep_q  <= `SUB_NONE;
        end else begin
            sub_rep_q  <= (sub_s > `SUB_TRX) ? `SUB_UNKNOWN : sub_s;
            health_q   <= (sub_s == `SUB_NONE) ? `TRI_NA :
                          (sub_flt_s || sub_s == `SUB_ERROR) ? `TRI_NO : `TRI_YES;
            coax_rep_q <= !coax_on ? `TRI_NA : coax_s ? `TRI_YES : `TRI_NO;
            opt1_rep_q <= !opt1_on ? `TRI_NA : opt1_s ? `TRI_YES : `TRI_NO;
            opt2_rep_q <= !opt2_on ? `TRI_NA : opt2_s ? `TRI_YES : `TRI_NO;
            lock_rep_q <= lock_rep_d;
            rate_rep_q <= rate_rep_d;
        end
    end

    // ----------------------------------------
    // Flash timer and outputs
    // ----------------------------------------
    reg [31:0] flash_cnt_q;
    reg        flash_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            flash_cnt_q <= 32'h0;
            flash_q     <= 1'b0;
        end else if (flash_cnt_q >= FLASH_HALF - 1) begin
            flash_cnt_q <= 32'h0;
            flash_q     <= !flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
        end
    end

    wire sig_loss = (coax_on && !coax_s) || (opt2_on && !opt2_s);

    always @(posedge aclk) begin
        if (!aresetn) begin
            reclock_bypass   <= 1'b1;
            rate_sel         <= `RATE_270;
            rate_fixed       <= 1'b0;
            output_invalid   <= 1'b0;
            optic1_tx_en     <= 1'b0;
            optic2_tx_en     <= 1'b0;
            input_sel_optic  <= 1'b0;
            indicator_a      <= 1'b0;
            config_indicator <= 1'b0;
            fault_led        <= 1'b0;
            mismatch_warn    <= 1'b0;
            state_yellow     <= 1'b0;
            alarm_fault      <= 1'b0;
            alarm_sig_loss   <= 1'b0;
            alarm_ref_loss   <= 1'b0;
            alarm_cfg_err    <= 1'b0;
        end else begin
            reclock_bypass   <= bypass_d;
            rate_sel         <= rate_d;
            rate_fixed       <= is_fixed(act_mode);
            output_invalid   <= invalid_d;
            // Enables only act when a submodule can carry them
            optic1_tx_en     <= (dual_fit || trx_fit) && act_q[`F_OPT1_EN];
            optic2_tx_en     <= dual_fit && act_q[`F_OPT2_EN];
            input_sel_optic  <= trx_fit && act_q[`F_IN_SEL];
            indicator_a      <= locate_q && flash_q;
            config_indicator <= locate_q && !flash_q;
            fault_led        <= mismatch ? flash_q : !rear_s;
            mismatch_warn    <= mismatch;
            state_yellow     <= rear_bad;
            alarm_fault      <= rear_bad || health_q == `TRI_NO;
            alarm_sig_loss   <= sig_loss;
            alarm_ref_loss   <= ref_lost_s;
            alarm_cfg_err    <= invalid_d || sub_s == `SUB_ERROR;
        end
    end

    // ----------------------------------------
    // Read channel, one cycle after address taken
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr & 8'hfc)
                `REG_SETTINGS: s_axi_rdata <= {25'h0, pend_q};
                `REG_ACTIVE:   s_axi_rdata <= {25'h0, act_q};
                `REG_COMMAND:  s_axi_rdata <= {29'h0, locate_q, 2'h0};
                `REG_STATUS:   s_axi_rdata <= {12'h0, rate_rep_q, lock_rep_q, opt2_rep_q,
                                               opt1_rep_q, coax_rep_q, health_q,
                                               sub_rep_q, mismatch_warn, reclock_bypass,
                                               output_invalid, 1'b0};
                `REG_ALARM:    s_axi_rdata <= {28'h0, alarm_cfg_err, alarm_ref_loss,
                                               alarm_sig_loss, alarm_fault};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// [verif/opt_sub_model.sv]
// Optical submodule model: type code, health and second optical receiver
`timescale 1ns/10ps
`include "reclock_ctrl_regs.vh"
module opt_sub_model (
    input  wire       aclk,
    input  wire [2:0] kind,
    input  wire       flt,
    input  wire       light,
    output reg  [2:0] sub_type,
    output reg        sub_fault,
    output reg        optic2_present
);
    // Pins settle a cycle late, like a slow plug-in
    always @(posedge aclk) begin
        sub_type <= kind;
        sub_fault <= flt && kind != `SUB_NONE;
        // Only the transceiver has a receiver; an absent pin pulls low
        optic2_present <= light && kind == `SUB_TRX;
    end
endmodule

// [verif/reclock_ctrl_assertions.sv]
// Port checker for the reclock control block
`timescale 1ns/10ps
module reclock_ctrl_assertions (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire front_is_16,
    input wire rear_present,
    input wire rear_is_16,
    input wire reclock_bypass,
    input wire rate_fixed,
    input wire output_invalid,
    input wire fault_led,
    input wire mismatch_warn,
    input wire state_yellow
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----
    // Pins need two cycles to clear the synchronisers and one more to reach the outputs; the checks wait five stable cycles
    // ----
    a_fixed_no_fallback: assert property (rate_fixed |-> !reclock_bypass)
        else $error("fixed mode routed around reclocker");
    a_invalid_needs_fixed: assert property (output_invalid |-> rate_fixed)
        else $error("invalid flag outside fixed mode");
    a_mismatch_yellow: assert property (mismatch_warn |-> state_yellow)
        else $error("mismatch without yellow state");
    a_big_front_warn: assert property
        ((front_is_16 && rear_present && !rear_is_16)[*5] |=> mismatch_warn)
        else $error("mismatch not raised");
    a_small_front_quiet: assert property ((!front_is_16)[*5] |=> !mismatch_warn)
        else $error("mismatch with small front");
    a_rear_missing_led: assert property ((!rear_present)[*5] |=> fault_led)
        else $error("fault lamp dark without rear");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped");
    a_no_aw_in_resp: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address open during response");
    cover property (mismatch_warn);
    cover property (output_invalid);
    cover property (reclock_bypass && !rate_fixed);
endmodule
bind reclock_ctrl reclock_ctrl_assertions reclock_ctrl_assertions_inst (.*);

// [verif/reclock_mode_and_status_control_bench.sv]
// Self-checking bench for the reclock control block
`timescale 1ns/10ps
`include "reclock_ctrl_regs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module reclock_mode_and_status_control_bench;
    logic aclk = 0, aresetn = 0, lock = 0, asi_detect = 0, sub_flt = 0, light = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, seed = 37, rd;
    logic [3:0] s_axi_wstrb = 4'hf, jumper_mode = 4'h7;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, ok, fx, by;
    logic [2:0] jumper_flags = 3'h2, sub_kind = 0, rate_detect = 0;
    logic coax_present = 0, optic1_present = 0, ref_lost = 0;
    logic front_is_16 = 0, rear_present = 1, rear_is_16 = 1;
    logic [2:0] pins [4] = '{3'h6, 3'h3, 3'h0, 3'h7};
    logic [1:0] rs;
    logic [6:0] prev = 7'h27;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] sub_type, rate_sel;
    wire sub_fault, optic2_present, reclock_bypass, rate_fixed, output_invalid;
    wire optic1_tx_en, optic2_tx_en, input_sel_optic, indicator_a, config_indicator;
    wire fault_led, mismatch_warn, state_yellow, alarm_fault, alarm_sig_loss;
    wire alarm_ref_loss, alarm_cfg_err;
    integer failures = 0, num_checks = 0, i, m, cnt, cnt2;
    // Short flash period keeps the run brief
    reclock_ctrl #(.FLASH_HALF(4)) reclock_ctrl_inst (.*);
    opt_sub_model opt_sub_model_inst (.aclk(aclk), .kind(sub_kind), .flt(sub_flt),
        .light(light), .sub_type(sub_type), .sub_fault(sub_fault),
        .optic2_present(optic2_present));
    always #20 aclk = ~aclk;
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task xfer(input bit w, input [7:0] a, input [31:0] d);
        integer n;
        n = 0;
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
        end
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 0;
                rs = s_axi_bresp;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 0;
                rs = s_axi_rresp;
                rd = s_axi_rdata;
            end
        end while ((s_axi_bready || s_axi_rready) && n < 100);
        if (n >= 100) begin
            failures++;
            give_verdict;
        end
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        failures++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        repeat (6) @(posedge aclk);
        xfer(0, `REG_SETTINGS, 0);
        `CHK(rd, 32'h27)
        sub_kind <= `SUB_TRX;
        for (m = 0; m < 10; m++) begin
            seed = xs(seed);
            lock <= seed[0];
            asi_detect <= seed[1];
            coax_present <= seed[2];
            light <= seed[3];
            optic1_present <= seed[7];
            rate_detect <= seed[10:8] % 6;
            xfer(1, `REG_SETTINGS, {seed[6:4], m[3:0]});
            xfer(0, `REG_ACTIVE, 0);
            `CHK(rd[6:0], prev)
            xfer(1, `REG_COMMAND, 1);
            prev = {seed[6:4], m[3:0]};
            repeat (6) @(posedge aclk);
            ok = (m == 0) ? rate_detect != `RATE_177 : !asi_detect;
            fx = m > 2 && m < 9;
            by = m == 2 || m > 8 || (m < 2 && !(lock && ok));
            `CHK(reclock_bypass, by)
            `CHK({rate_fixed, output_invalid}, {fx, fx && !lock})
            if (fx) `CHK(rate_sel, m - 3)
            `CHK({input_sel_optic, optic1_tx_en}, {seed[6], seed[4]})
            `CHK(optic2_tx_en, 1'b0)
            xfer(0, `REG_STATUS, 0);
            if (m == 2) `CHK(rd[19:15], {`RATE_NA, `TRI_NA})
            if (fx) `CHK(rd[16:15], lock ? `TRI_YES : `TRI_NO)
            if (m < 2 && !ok) `CHK(rd[19:17], `RATE_UNKNOWN)
            `CHK(rd[10:9], seed[6] ? `TRI_NA : {1'b0, !seed[2]})
            `CHK(rd[14:13], seed[6] ? {1'b0, !seed[3]} : `TRI_NA)
            `CHK(rd[12:11], seed[4] ? {1'b0, !seed[7]} : `TRI_NA)
        end
        for (i = 0; i < 8; i++) begin
            sub_kind <= i;
            sub_flt <= i[0];
            repeat (8) @(posedge aclk);
            xfer(0, `REG_STATUS, 0);
            `CHK(rd[6:4], i > 4 ? `SUB_UNKNOWN : i[2:0])
            `CHK(rd[8:7], i == 0 ? `TRI_NA : {1'b0, i[0]})
            `CHK(alarm_cfg_err, i == 1)
            `CHK(optic1_tx_en, i > 2 && i < 5 && prev[4])
            `CHK(optic2_tx_en, i == 3 && prev[5])
            `CHK(input_sel_optic, i == 4 && prev[6])
        end
        for (i = 0; i < 4; i++) begin
            {front_is_16, rear_present, rear_is_16} <= pins[i];
            repeat (8) @(posedge aclk);
            cnt = 0;
            repeat (20) @(posedge aclk) cnt += fault_led;
            `CHK({mismatch_warn, state_yellow}, {i == 0, i == 0 || i == 2})
            `CHK(cnt, i == 0 ? cnt % 20 + (cnt == 0) * 99 : (i == 2) * 20)
        end
        xfer(1, `REG_COMMAND, 4);
        cnt = 0;
        cnt2 = 0;
        repeat (20) begin
            @(posedge aclk);
            cnt += indicator_a;
            cnt2 += config_indicator;
        end
        `CHK(cnt > 0 && cnt < 20 && cnt2 > 0 && cnt2 < 20, 1)
        xfer(1, `REG_COMMAND, 0);
        repeat (4) @(posedge aclk);
        `CHK({indicator_a, config_indicator}, 2'b00)
        jumper_mode <= `MODE_BYPASS;
        jumper_flags <= 3'h5;
        repeat (4) @(posedge aclk);
        xfer(1, `REG_COMMAND, 2);
        xfer(0, `REG_ACTIVE, 0);
        `CHK(rd[6:0], 7'h52)
        ref_lost <= 1;
        repeat (6) @(posedge aclk);
        xfer(0, `REG_ALARM, 0);
        `CHK({alarm_ref_loss, rd[3:0]}, {3'b101, !coax_present, 1'b1})
        // Write the saved setup back to settings and apply it: active takes it again
        xfer(1, `REG_SETTINGS, prev);
        xfer(1, `REG_COMMAND, 1);
        xfer(0, `REG_ACTIVE, 0);
        `CHK(rd[6:0], prev)
        xfer(0, 8'h20, 0);
        `CHK({rs, rd}, {2'h2, 32'h0})
        give_verdict;
    end
endmodule
